// ==== src/scp_map.vh ====
// register layout and protocol constants for the serial command port
`ifndef SCP_MAP_VH
`define SCP_MAP_VH
`define SCP_BITS_PER_BYTE      4'h8
`define SCP_CNT_RESET          4'h0
`define SCP_STAT_ACTIVE_MSB    7
`define SCP_STAT_ACTIVE_LSB    4
`define SCP_STAT_NRDY_MSB      3
`define SCP_STAT_NRDY_LSB      0
`define SCP_STAT_RESET         8'hFF
`define SCP_CMD_RESET          8'h00
`define SCP_CLK_PERIOD_NS      4
`define SCP_BUSY_TIME_NS       40
`define SCP_BUSY_CYCLES        ((`SCP_BUSY_TIME_NS + `SCP_CLK_PERIOD_NS - 1) / `SCP_CLK_PERIOD_NS)
`endif

// ==== src/scp_port.v ====
// serial command port: host writes command bytes, reads channel status
// Operation
// - select low enables input and status output
// - command bits arrive MSB first per pulse
// - execute byte at eighth sampling edge
// - strap low: sample rising, launch falling
// - strap high: sample falling, launch rising
// - status shifts out while select low
// - select high clears the pulse counter
// - active flags ch4..ch1 in bits 7..4
// - not-ready flags ch4..ch1 in bits 3..0
// - active low while processing or playing
// - not-ready low while processing or standby
// - command pending low while command processes
// - data output high impedance while deselected
// - commands are whole bytes, maybe two; CMD_SECOND_O stays low, pairing left to the decoder
`timescale 1ns/1ns
`include "scp_map.vh"
module scp_port (
  // clock and reset
  input  wire       CLK_I,
  input  wire       SYS_RST_I,
  // serial pins from host
  input  wire       PORT_SELECT_N_I,
  input  wire       SER_CLK_I,
  input  wire       SER_DATA_I,
  input  wire       EDGE_POLARITY_STRAP_I,
  // serial data output pin, enable high while driving
  output wire       SER_DATA_O,
  output wire       SER_DATA_OE_O,
  // channel state from the playback engine
  input  wire [3:0] CHAN_PLAYING_I,
  input  wire [3:0] CHAN_STANDBY_I,
  input  wire       CMD_DONE_I,
  // received command bytes toward the decoder
  output wire [7:0] CMD_BYTE_O,
  output wire       CMD_VALID_O,
  output wire       CMD_SECOND_O,
  // command pending, active low
  output wire       COMMAND_PENDING_N_O,
  // status register view
  output wire [7:0] CHANNEL_STATUS_O
);
  // synchronised pin levels
  wire       sel_n_inv;
  wire       sel_n_s;
  wire       sck_s;
  wire       sdi_s;
  wire       strap_s;

  // edge detection and framing state
  reg        sck_prev_q;
  reg        sel_n_prev_q;
  reg  [3:0] bit_cnt_q;
  reg  [3:0] bit_cnt_d;
  reg  [7:0] rx_shift_q;
  reg  [7:0] rx_shift_d;
  reg  [7:0] tx_shift_q;
  reg  [7:0] tx_shift_d;
  reg        sdo_q;
  reg        sdo_d;
  reg        sdo_oe_q;

  // command handover and status
  reg  [7:0] cmd_byte_q;
  reg  [7:0] cmd_byte_d;
  reg        cmd_valid_q;
  reg        cmd_valid_d;
  reg        cmd_second_q;
  reg        byte_phase_q;
  reg        pending_q;
  reg        pending_d;
  reg        pending_n_q;
  reg  [7:0] status_q;

  // decoded events, all on the system clock
  wire       rise;
  wire       fall;
  wire       sample_edge;
  wire       launch_edge;
  wire       sel_assert;
  wire       selected;
  wire       byte_end;
  wire [7:0] status_now;

  // pick one of the two serial clock edges by strap level
  function pick_edge;
    input strap;
    input when_low;
    input when_high;
    begin
      pick_edge = strap ? when_high : when_low;
    end
  endfunction

  // true on the last bit of a byte
  function is_last_bit;
    input [3:0] cnt;
    begin
      is_last_bit = (cnt == (`SCP_BITS_PER_BYTE - 4'h1));
    end
  endfunction

  // flag is low when pending or the channel is in that state
  function [3:0] flags_n;
    input [3:0] state;
    input       busy;
    begin
      flags_n = ~(state | {4{busy}});
    end
  endfunction

  // one synchroniser per pin; strap is a pin too
  scp_sync u_sync_sel (
    .CLK_I     (CLK_I),
    .SYS_RST_I (SYS_RST_I),
    .async_i   (~PORT_SELECT_N_I),
    .sync_o    (sel_n_inv)
  );

  scp_sync u_sync_sck (
    .CLK_I     (CLK_I),
    .SYS_RST_I (SYS_RST_I),
    .async_i   (SER_CLK_I),
    .sync_o    (sck_s)
  );

  scp_sync u_sync_sdi (
    .CLK_I     (CLK_I),
    .SYS_RST_I (SYS_RST_I),
    .async_i   (SER_DATA_I),
    .sync_o    (sdi_s)
  );

  scp_sync u_sync_strap (
    .CLK_I     (CLK_I),
    .SYS_RST_I (SYS_RST_I),
    .async_i   (EDGE_POLARITY_STRAP_I),
    .sync_o    (strap_s)
  );

  // select enters inverted so a reset synchroniser reads deselected
  assign sel_n_s     = ~sel_n_inv;
  assign selected    = ~sel_n_s;
  assign rise        = sck_s & ~sck_prev_q;
  assign fall        = ~sck_s & sck_prev_q;
  assign sample_edge = pick_edge(strap_s, rise, fall);
  assign launch_edge = pick_edge(strap_s, fall, rise);
  assign sel_assert  = selected & sel_n_prev_q;
  assign byte_end    = selected & sample_edge & is_last_bit(bit_cnt_q);

  // flags are low when pending or channel in that state
  assign status_now[`SCP_STAT_ACTIVE_MSB:`SCP_STAT_ACTIVE_LSB] =
    flags_n(CHAN_PLAYING_I, pending_q);
  assign status_now[`SCP_STAT_NRDY_MSB:`SCP_STAT_NRDY_LSB] =
    flags_n(CHAN_STANDBY_I, pending_q);

  // bit counter and receive shifter
  always @* begin
    bit_cnt_d  = bit_cnt_q;
    rx_shift_d = rx_shift_q;
    if (sel_n_s) begin
      bit_cnt_d = `SCP_CNT_RESET;
    end else if (sample_edge) begin
      rx_shift_d = {rx_shift_q[6:0], sdi_s};
      if (is_last_bit(bit_cnt_q)) begin
        bit_cnt_d = `SCP_CNT_RESET;
      end else begin
        bit_cnt_d = bit_cnt_q + 4'h1;
      end
    end
  end

  // command handover and pending flag
  always @* begin
    cmd_byte_d  = cmd_byte_q;
    cmd_valid_d = 1'b0;
    pending_d   = pending_q;
    if (byte_end) begin
      cmd_byte_d  = {rx_shift_q[6:0], sdi_s};
      cmd_valid_d = 1'b1;
      // set wins over a done in the same cycle
      pending_d   = 1'b1;
    end else if (CMD_DONE_I) begin
      pending_d   = 1'b0;
    end
  end

  // status shifter, loaded once per select
  always @* begin
    tx_shift_d = tx_shift_q;
    sdo_d      = sdo_q;
    if (sel_assert) begin
      // snapshot so the byte cannot change mid-read
      tx_shift_d = {status_now[6:0], 1'b1};
      sdo_d      = status_now[7];
    end else if (selected && launch_edge) begin
      sdo_d      = tx_shift_q[7];
      tx_shift_d = {tx_shift_q[6:0], 1'b1};
    end
  end

  // previous serial clock level for edge finding
  always @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      sck_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= sck_s;
    end
  end

  // previous select level for the load strobe
  always @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      sel_n_prev_q <= 1'b1;
    end else begin
      sel_n_prev_q <= sel_n_s;
    end
  end

  // receive side registers
  always @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      bit_cnt_q  <= `SCP_CNT_RESET;
      rx_shift_q <= `SCP_CMD_RESET;
    end else begin
      bit_cnt_q  <= bit_cnt_d;
      rx_shift_q <= rx_shift_d;
    end
  end

  // byte handed over, held until the next one
  always @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      cmd_byte_q   <= `SCP_CMD_RESET;
      cmd_second_q <= 1'b0;
      byte_phase_q <= 1'b0;
    end else begin
      cmd_byte_q <= cmd_byte_d;
      if (byte_end) begin
        cmd_second_q <= byte_phase_q;
        // pairing of two-byte commands is left to the decoder
        byte_phase_q <= 1'b0;
      end
    end
  end

  // one-cycle strobe for a new byte
  always @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      cmd_valid_q <= 1'b0;
    end else begin
      cmd_valid_q <= cmd_valid_d;
    end
  end

  // both polarities kept so the pin comes straight from a flop
  always @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      pending_q   <= 1'b0;
      pending_n_q <= 1'b1;
    end else begin
      pending_q   <= pending_d;
      pending_n_q <= ~pending_d;
    end
  end

  // serial output data
  always @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      tx_shift_q <= `SCP_STAT_RESET;
      sdo_q      <= 1'b0;
    end else begin
      tx_shift_q <= tx_shift_d;
      sdo_q      <= sdo_d;
    end
  end

  // output enable follows the synchronised select
  always @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      sdo_oe_q <= 1'b0;
    end else begin
      sdo_oe_q <= selected;
    end
  end

  // status register view
  always @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      status_q <= `SCP_STAT_RESET;
    end else begin
      status_q <= status_now;
    end
  end

  assign SER_DATA_O          = sdo_q;
  assign SER_DATA_OE_O       = sdo_oe_q;
  assign CMD_BYTE_O          = cmd_byte_q;
  assign CMD_VALID_O         = cmd_valid_q;
  assign CMD_SECOND_O        = cmd_second_q;
  assign COMMAND_PENDING_N_O = pending_n_q;
  assign CHANNEL_STATUS_O    = status_q;
endmodule

// ==== src/scp_sync.v ====
// two-flop synchroniser for one input from outside the clock domain
`timescale 1ns/1ns
module scp_sync (
  // clock and reset
  input  wire CLK_I,
  input  wire SYS_RST_I,
  // asynchronous level in, synchronised level out
  input  wire async_i,
  output wire sync_o
);
  reg meta_q;
  reg sync_q;

  always @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule

// ==== testbench/scp_host.sv ====
// host model framing bytes on the serial pins
`timescale 1ns/1ns
module scp_host (
  output reg  sel_n_o, sck_o, sdi_o,
  input  wire sdo_i
);
  initial begin
    sel_n_o = 1'b1;
    sck_o = 1'b0;
    sdi_o = 1'b0;
  end
  task xfer(input [7:0] tx, input pol, input integer n, output [7:0] rx);
    integer i;
    begin
      sck_o = pol;
      #62 sel_n_o = 1'b0;
      for (i = 0; i < n; i = i + 1) begin
        sdi_o = tx[7 - i];
        #62 sck_o = ~pol;
        rx[7 - i] = sdo_i;
        #63 sck_o = pol;
      end
      #62 sel_n_o = 1'b1;
      // flip so a stale bit is never mistaken for data
      sdi_o = ~sdi_o;
    end
  endtask
endmodule

// ==== testbench/scp_monitor.sv ====
// checker for the serial command port
`timescale 1ns/1ns
module scp_monitor (
  input wire       CLK_I, SYS_RST_I, PORT_SELECT_N_I, CMD_DONE_I,
  input wire [3:0] CHAN_PLAYING_I, CHAN_STANDBY_I,
  input wire       SER_DATA_OE_O, CMD_VALID_O, COMMAND_PENDING_N_O,
  input wire [7:0] CMD_BYTE_O, CHANNEL_STATUS_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  wire busy = !COMMAND_PENDING_N_O;
  property p_oe_off; PORT_SELECT_N_I [*6] |-> !SER_DATA_OE_O; endproperty
  a_oe_off: assert property (p_oe_off) else $error("out driven idle");
  property p_idle; PORT_SELECT_N_I [*6] |-> !CMD_VALID_O; endproperty
  a_idle: assert property (p_idle) else $error("byte while idle");
  property p_pulse; CMD_VALID_O |=> !CMD_VALID_O; endproperty
  a_pulse: assert property (p_pulse) else $error("long valid");
  property p_byte; $changed(CMD_BYTE_O) |-> CMD_VALID_O; endproperty
  a_byte: assert property (p_byte) else $error("byte moved");
  property p_pset; CMD_VALID_O |-> ##[0:1] busy; endproperty
  a_pset: assert property (p_pset) else $error("no pending");
  property p_phold; busy && !CMD_DONE_I |=> busy; endproperty
  a_phold: assert property (p_phold) else $error("pending lost");
  // only while pending is steady, so either pending stage may feed status
  property p_act; !$past(SYS_RST_I) && $stable(busy) |->
    CHANNEL_STATUS_O[7:4] == ~($past(CHAN_PLAYING_I) | {4{busy}}); endproperty
  a_act: assert property (p_act) else $error("active bad");
  property p_nrdy; !$past(SYS_RST_I) && $stable(busy) |->
    CHANNEL_STATUS_O[3:0] == ~($past(CHAN_STANDBY_I) | {4{busy}}); endproperty
  a_nrdy: assert property (p_nrdy) else $error("ready bad");
endmodule
bind scp_port scp_monitor mon (.*);

// ==== testbench/serial_command_port_bench.sv ====
// bench for the serial command port
`timescale 1ns/1ns
module serial_command_port_bench;
  reg        CLK_I = 1'b0, SYS_RST_I = 1'b1, EDGE_POLARITY_STRAP_I = 1'b0, CMD_DONE_I = 1'b0;
  reg  [3:0] CHAN_PLAYING_I = 4'h0, CHAN_STANDBY_I = 4'h0;
  reg  [7:0] tx, rx, got;
  wire       PORT_SELECT_N_I, SER_CLK_I, SER_DATA_I, SER_DATA_O, SER_DATA_OE_O, sdo;
  wire       CMD_VALID_O, CMD_SECOND_O, COMMAND_PENDING_N_O;
  wire [7:0] CMD_BYTE_O, CHANNEL_STATUS_O;
  integer    num_errors = 0, compares = 0, cyc = 0, k;
  assign sdo = SER_DATA_OE_O ? SER_DATA_O : 1'bz;
  initial forever #2 CLK_I = ~CLK_I;
  scp_host host (.sel_n_o(PORT_SELECT_N_I), .sck_o(SER_CLK_I), .sdi_o(SER_DATA_I), .sdo_i(sdo));
  scp_port uut (.*);
  function [7:0] st(input busy);
    st = {~(CHAN_PLAYING_I | {4{busy}}), ~(CHAN_STANDBY_I | {4{busy}})};
  endfunction
  task check(input [7:0] a, input [7:0] e);
    begin
      compares = compares + 1;
      if (a !== e) begin
        num_errors = num_errors + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e);
      end
    end
  endtask
  task final_report;
    begin
      if (num_errors == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  always @(posedge CLK_I) begin
    cyc <= cyc + 1;
    if (CMD_VALID_O === 1'b1) got <= CMD_BYTE_O;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      final_report;
    end
  end
  initial begin
    k = $urandom(32'h169fc02a);
    repeat (12) @(posedge CLK_I);
    @(negedge CLK_I) SYS_RST_I = 1'b0;
    for (k = 0; k < 12; k = k + 1) begin
      @(negedge CLK_I);
      EDGE_POLARITY_STRAP_I = k[0];
      CHAN_PLAYING_I = 4'($urandom);
      CHAN_STANDBY_I = 4'($urandom);
      tx = (k < 2) ? {8{k[0]}} : 8'($urandom);
      repeat (8) @(negedge CLK_I);
      check(CHANNEL_STATUS_O, st(1'b0));
      if (k == 5) host.xfer(~tx, k[0], 3, rx);
      host.xfer(tx, k[0], 8, rx);
      check(got, tx);
      check({7'h00, CMD_SECOND_O}, 8'h00);
      check(rx, st(1'b0));
      @(negedge CLK_I);
      check(CHANNEL_STATUS_O, st(1'b1));
      check({7'h00, COMMAND_PENDING_N_O}, 8'h00);
      CMD_DONE_I = 1'b1;
      @(negedge CLK_I) CMD_DONE_I = 1'b0;
      repeat (2) @(negedge CLK_I);
      check({7'h00, COMMAND_PENDING_N_O}, 8'h01);
    end
    final_report;
  end
endmodule
